// ===== src/twb_regs.vh
// timing constants and protocol codes of the two-wire bus protocol block
`ifndef TWB_REGS_VH
`define TWB_REGS_VH
`define TWB_CLK_HZ        125000000
`define TWB_MAX_BUS_HZ    400000
// quarter bit period at the fastest rate, in system cycles
`define TWB_QTR_CYC       (`TWB_CLK_HZ / (4 * `TWB_MAX_BUS_HZ))
`define TWB_GCALL_ADDR    7'h00
`define TWB_RSVD_HI       4'hF
`define TWB_BITS_PER_PKT  4'h9
`endif

// ===== src/twb_sync.v
// two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
module twb_sync (
    input  wire ref_clk_i,
    input  wire rst_n_i,
    input  wire async_i,
    output wire level_o,
    output wire rise_o,
    output wire fall_o
);
    reg meta_reg;
    reg sync_reg;
    reg last_reg;
    // three flops, the first read only by the second
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end
    assign level_o = sync_reg;
    assign rise_o  = sync_reg & ~last_reg;
    assign fall_o  = ~sync_reg & last_reg;
endmodule

// ===== src/twb_protocol.v
// two-wire bus protocol engine: master and slave roles, start/stop, packets
`timescale 1ns/1ps
`include "twb_regs.vh"
module twb_protocol #(
    parameter QTR_CYC = `TWB_QTR_CYC
) (
    input  wire       ref_clk_i,
    input  wire       rst_n_i,
    input  wire       bus_power_gate_bit_i,
    // bus lines, open drain
    input  wire       scl_i,
    output wire       scl_o,
    output wire       scl_oe_o,
    input  wire       sda_i,
    output wire       sda_o,
    output wire       sda_oe_o,
    // slave setup
    input  wire [6:0] own_addr_i,
    input  wire       gcall_en_i,
    // master command: start, byte, stop
    input  wire       cmd_start_i,
    input  wire       cmd_write_i,
    input  wire       cmd_read_i,
    input  wire       cmd_stop_i,
    input  wire [7:0] cmd_data_i,
    input  wire       cmd_ack_i,
    output wire       cmd_ready_o,
    output reg        cmd_done_o,
    output reg        cmd_nack_o,
    // slave side user data
    input  wire [7:0] slv_tx_data_i,
    input  wire       slv_ack_i,
    output reg        slv_addr_hit_o,
    output reg        slv_read_o,
    output reg        slv_gcall_o,
    output reg        slv_rx_valid_o,
    output reg  [7:0] slv_rx_data_o,
    output reg        slv_tx_req_o,
    output reg        slv_rx_nack_o,
    // bus state and shared read data
    output reg        bus_busy_o,
    output reg  [7:0] rd_data_o,
    output reg        start_seen_o,
    output reg        stop_seen_o
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam M_IDLE  = 3'h0;
    localparam M_START = 3'h1;
    localparam M_LOW   = 3'h2;
    localparam M_HIGH  = 3'h3;
    localparam M_HOLD  = 3'h4;
    localparam M_STOP  = 3'h5;
    localparam S_IDLE  = 2'h0;
    localparam S_ADDR  = 2'h1;
    localparam S_DATA  = 2'h2;
    // four quarters per bit keep the bus at 400 kHz
    localparam [31:0] QTR_W = QTR_CYC;
    localparam [15:0] QTR   = QTR_W[15:0];

    wire scl_lvl;
    wire scl_rise;
    wire scl_fall;
    wire sda_lvl;
    wire sda_rise;
    wire sda_fall;

    reg  [2:0]  m_state_reg;
    reg  [15:0] m_cnt_reg;
    reg  [3:0]  m_bit_reg;
    reg  [8:0]  m_shift_reg;
    reg         m_rep_reg;
    reg         m_first_reg;
    reg         m_scl_low_reg;
    reg         m_sda_low_reg;
    reg  [1:0]  s_state_reg;
    reg  [3:0]  s_bit_reg;
    reg  [7:0]  s_shift_reg;
    reg  [7:0]  s_tx_reg;
    reg         s_rd_reg;
    reg         s_sda_low_reg;
    reg         s_ackbit_reg;
    reg         s_sent_ack_reg;

    wire active = ~bus_power_gate_bit_i;
    wire m_own  = m_state_reg != M_IDLE;

    // ------------------------------------------------------------
    // line sampling
    // ------------------------------------------------------------
    twb_sync u_scl (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (scl_i),
        .level_o   (scl_lvl),
        .rise_o    (scl_rise),
        .fall_o    (scl_fall)
    );
    twb_sync u_sda (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (sda_i),
        .level_o   (sda_lvl),
        .rise_o    (sda_rise),
        .fall_o    (sda_fall)
    );

    wire start_det = active & sda_fall & scl_lvl;
    wire stop_det  = active & sda_rise & scl_lvl;

    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_o = active & m_scl_low_reg;
    assign sda_oe_o = active & (m_sda_low_reg | s_sda_low_reg);

    // no new start while another master holds the bus
    assign cmd_ready_o = active & (m_state_reg == M_HOLD ||
                         (m_state_reg == M_IDLE && !bus_busy_o));

    // ------------------------------------------------------------
    // bus busy tracking and condition flags
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (!rst_n_i || !active) begin
            bus_busy_o   <= 1'b0;
            start_seen_o <= 1'b0;
            stop_seen_o  <= 1'b0;
        end else begin
            start_seen_o <= start_det;
            stop_seen_o  <= stop_det;
            if (start_det)
                bus_busy_o <= 1'b1;
            else if (stop_det)
                bus_busy_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // master engine: one bit per four quarter periods
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (!rst_n_i || !active) begin
            m_state_reg   <= M_IDLE;
            m_cnt_reg     <= 16'h0000;
            m_bit_reg     <= 4'h0;
            m_shift_reg   <= 9'h1FF;
            m_rep_reg     <= 1'b0;
            m_first_reg   <= 1'b0;
            m_scl_low_reg <= 1'b0;
            m_sda_low_reg <= 1'b0;
            cmd_done_o    <= 1'b0;
            cmd_nack_o    <= 1'b0;
            rd_data_o     <= 8'h00;
        end else begin
            cmd_done_o <= 1'b0;
            if (m_cnt_reg != 16'h0000)
                m_cnt_reg <= m_cnt_reg - 16'h0001;
            case (m_state_reg)
                M_IDLE: begin
                    if (cmd_start_i && !bus_busy_o) begin
                        m_state_reg <= M_START;
                        m_rep_reg   <= 1'b0;
                        m_cnt_reg   <= QTR + QTR;
                    end
                end
                M_START: begin
                    // data falls only with clock released high
                    if (m_cnt_reg == QTR && scl_lvl && sda_lvl)
                        m_sda_low_reg <= 1'b1;
                    else if (m_cnt_reg == 16'h0000) begin
                        m_scl_low_reg <= 1'b1;
                        m_first_reg   <= 1'b1;
                        m_state_reg   <= M_HOLD;
                        cmd_done_o    <= 1'b1;
                    end
                end
                M_HOLD: begin
                    // clock parked low awaiting the next command
                    if (cmd_write_i || cmd_read_i) begin
                        // msb first, ninth slot is acknowledge
                        m_shift_reg <= cmd_read_i ? {8'hFF, ~cmd_ack_i}
                                                  : {cmd_data_i, 1'b1};
                        m_bit_reg   <= 4'h0;
                        m_cnt_reg   <= QTR + QTR;
                        m_state_reg <= M_LOW;
                    end else if (cmd_start_i) begin
                        m_rep_reg     <= 1'b1;
                        m_sda_low_reg <= 1'b0;
                        m_cnt_reg     <= QTR;
                        m_state_reg   <= M_STOP;
                    end else if (cmd_stop_i && !m_first_reg) begin
                        // stop after any packet, acked or not
                        m_sda_low_reg <= 1'b1;
                        m_rep_reg     <= 1'b0;
                        m_cnt_reg     <= QTR;
                        m_state_reg   <= M_STOP;
                    end
                end
                M_LOW: begin
                    // data changes only in the low phase
                    if (m_cnt_reg == QTR) // middle of the low half
                        m_sda_low_reg <= ~m_shift_reg[8];
                    if (m_cnt_reg == 16'h0000) begin
                        m_scl_low_reg <= 1'b0;
                        m_state_reg   <= M_HIGH;
                        m_cnt_reg     <= QTR + QTR;
                    end
                end
                M_HIGH: begin
                    // wait while a slave stretches the clock
                    // high time counts once the line is high
                    if (!scl_lvl)
                        m_cnt_reg <= QTR + QTR;
                    else if (m_cnt_reg == 16'h0000) begin
                        m_scl_low_reg <= 1'b1;
                        m_shift_reg   <= {m_shift_reg[7:0], sda_lvl};
                        m_cnt_reg     <= QTR + QTR;
                        if (m_bit_reg == `TWB_BITS_PER_PKT - 4'h1) begin
                            cmd_nack_o  <= sda_lvl;
                            rd_data_o   <= m_shift_reg[7:0];
                            cmd_done_o  <= 1'b1;
                            m_first_reg <= 1'b0;
                            m_state_reg <= M_HOLD;
                        end else begin
                            m_bit_reg   <= m_bit_reg + 4'h1;
                            m_state_reg <= M_LOW;
                        end
                    end
                end
                M_STOP: begin
                    // release clock, then move data with clock high
                    if (m_cnt_reg == 16'h0000 && m_scl_low_reg) begin
                        m_scl_low_reg <= 1'b0;
                        m_cnt_reg     <= QTR + QTR;
                    end else if (m_cnt_reg == 16'h0000 && scl_lvl) begin
                        // stop is a rising data edge with clock high
                        m_sda_low_reg <= 1'b0;
                        if (m_rep_reg) begin
                            m_cnt_reg   <= QTR + QTR;
                            m_state_reg <= M_START;
                        end else begin
                            m_state_reg <= M_IDLE;
                            cmd_done_o  <= 1'b1;
                        end
                    end else if (!scl_lvl && !m_scl_low_reg)
                        m_cnt_reg <= QTR + QTR;
                end
                default: m_state_reg <= M_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // slave engine: shifts on clock edges seen on the line
    // ------------------------------------------------------------
    wire [6:0] rx_addr    = s_shift_reg[6:0];
    wire       rsvd_addr  = rx_addr[6:3] == `TWB_RSVD_HI;
    // general call accepted with write bit only
    wire       gcall_hit  = gcall_en_i && rx_addr == `TWB_GCALL_ADDR && !sda_lvl;
    wire       own_hit    = rx_addr == own_addr_i && !rsvd_addr &&
                            own_addr_i != `TWB_GCALL_ADDR;

    always @(posedge ref_clk_i) begin
        if (!rst_n_i || !active) begin
            s_state_reg    <= S_IDLE;
            s_bit_reg      <= 4'h0;
            s_shift_reg    <= 8'h00;
            s_tx_reg       <= 8'hFF;
            s_rd_reg       <= 1'b0;
            s_sda_low_reg  <= 1'b0;
            s_ackbit_reg   <= 1'b0;
            s_sent_ack_reg <= 1'b0;
            slv_addr_hit_o <= 1'b0;
            slv_read_o     <= 1'b0;
            slv_gcall_o    <= 1'b0;
            slv_rx_valid_o <= 1'b0;
            slv_rx_data_o  <= 8'h00;
            slv_tx_req_o   <= 1'b0;
            slv_rx_nack_o  <= 1'b0;
        end else begin
            slv_addr_hit_o <= 1'b0;
            slv_rx_valid_o <= 1'b0;
            slv_tx_req_o   <= 1'b0;
            slv_rx_nack_o  <= 1'b0;
            if (start_det && !m_own) begin
                s_state_reg   <= S_ADDR;
                // the start's own clock fall wraps this to zero
                s_bit_reg     <= 4'hF;
                s_sda_low_reg <= 1'b0;
            end else if (stop_det) begin
                s_state_reg   <= S_IDLE;
                s_sda_low_reg <= 1'b0;
            end else if (s_state_reg != S_IDLE && scl_rise) begin
                if (s_bit_reg == 4'h8) begin
                    // acknowledge slot sampled by the transmitter side
                    if (s_rd_reg && s_state_reg == S_DATA && sda_lvl) begin
                        slv_rx_nack_o <= 1'b1;
                        s_state_reg   <= S_IDLE;
                    end
                end else if (s_bit_reg == 4'h7 && s_state_reg == S_ADDR) begin
                    // matched slave will pull the ninth bit low
                    s_rd_reg       <= sda_lvl;
                    s_ackbit_reg   <= own_hit | gcall_hit;
                    slv_addr_hit_o <= own_hit | gcall_hit;
                    slv_read_o     <= sda_lvl;
                    slv_gcall_o    <= gcall_hit;
                    if (!(own_hit | gcall_hit))
                        s_state_reg <= S_IDLE;
                end else begin
                    s_shift_reg <= {s_shift_reg[6:0], sda_lvl};
                    if (s_bit_reg == 4'h7 && !s_rd_reg) begin
                        slv_rx_valid_o <= 1'b1;
                        slv_rx_data_o  <= {s_shift_reg[6:0], sda_lvl};
                        // user withholds ack for final byte
                        s_ackbit_reg   <= slv_ack_i;
                    end
                end
            end else if (s_state_reg != S_IDLE && scl_fall) begin
                s_bit_reg <= (s_bit_reg == 4'h8) ? 4'h0 : s_bit_reg + 4'h1;
                if (s_bit_reg == 4'h7) begin
                    s_sent_ack_reg <= ~(s_rd_reg & s_state_reg == S_DATA);
                    s_sda_low_reg  <= ~(s_rd_reg & s_state_reg == S_DATA) & s_ackbit_reg;
                end else if (s_bit_reg == 4'h8) begin
                    if (s_state_reg == S_ADDR)
                        s_state_reg <= S_DATA;
                    if (s_rd_reg && (s_state_reg == S_ADDR || !sda_lvl)) begin
                        // slave transmits next byte, msb first
                        s_tx_reg      <= {slv_tx_data_i[6:0], 1'b1};
                        s_sda_low_reg <= ~slv_tx_data_i[7];
                        slv_tx_req_o  <= 1'b1;
                    end else
                        s_sda_low_reg <= 1'b0;
                    // a write nacked by us ends participation
                    if (!s_rd_reg && s_sent_ack_reg && !s_ackbit_reg)
                        s_state_reg <= S_IDLE;
                end else if (s_rd_reg && s_state_reg == S_DATA) begin
                    s_sda_low_reg <= ~s_tx_reg[7];
                    s_tx_reg      <= {s_tx_reg[6:0], 1'b1};
                end
            end
        end
    end
endmodule

// ===== dv/twb_protocol_monitor.sv
// port-level assertion checker for the two-wire bus protocol engine
`timescale 1ns/1ps
module twb_protocol_monitor #(
    parameter QTR_CYC = 78
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire bus_power_gate_bit_i,
    input wire scl_i,
    input wire scl_o,
    input wire scl_oe_o,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_o,
    input wire cmd_done_o,
    input wire cmd_nack_o,
    input wire slv_addr_hit_o,
    input wire slv_gcall_o,
    input wire slv_rx_valid_o,
    input wire bus_busy_o
);
    localparam int WIN = 2 * QTR_CYC + 4;
    localparam int HI_MIN = QTR_CYC;
    reg [15:0] hi_cnt_reg;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // cycles the clock line has stood high
    always @(posedge ref_clk_i) begin
        if (!rst_n_i || !scl_i)
            hi_cnt_reg <= 16'h0000;
        else if (hi_cnt_reg != 16'hFFFF)
            hi_cnt_reg <= hi_cnt_reg + 16'h0001;
    end
    property p_open_drain;
        scl_o == 1'b0 && sda_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("bus line driven high");
    property p_gate_quiet;
        bus_power_gate_bit_i [*3] |-> !scl_oe_o && !sda_oe_o && !bus_busy_o && !cmd_done_o;
    endproperty
    a_gate_quiet: assert property (p_gate_quiet) else $error("gated block still active");
    property p_edge_hi;
        $changed(sda_oe_o) && scl_i && $past(scl_i, 4) |-> ##[0:WIN] cmd_done_o;
    endproperty
    a_edge_hi: assert property (p_edge_hi) else $error("data moved with clock high");
    property p_busy_rise;
        $rose(bus_busy_o) |-> !sda_i;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy without start");
    property p_busy_fall;
        $fell(bus_busy_o) && !bus_power_gate_bit_i |-> sda_i && scl_i;
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy dropped without stop");
    property p_stretch;
        $rose(scl_oe_o) |-> hi_cnt_reg >= HI_MIN;
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock high phase too short");
    property p_ack_addr;
        slv_addr_hit_o |-> ##[1:40] sda_oe_o;
    endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("matched address not acked");
    property p_done_one;
        cmd_done_o |=> !cmd_done_o;
    endproperty
    a_done_one: assert property (p_done_one) else $error("done longer than one cycle");
    c_nack: cover property (cmd_done_o && cmd_nack_o);
    c_gcall: cover property (slv_addr_hit_o && slv_gcall_o);
    c_rx: cover property (slv_rx_valid_o);
    c_stretch: cover property ($fell(scl_oe_o) ##1 !scl_i [*3]);
endmodule

bind twb_protocol twb_protocol_monitor #(.QTR_CYC(QTR_CYC)) twb_protocol_monitor_inst (
    .ref_clk_i, .rst_n_i, .bus_power_gate_bit_i, .scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o, .sda_oe_o,
    .cmd_done_o, .cmd_nack_o, .slv_addr_hit_o, .slv_gcall_o, .slv_rx_valid_o, .bus_busy_o
);

// ===== dv/twb_far_end.sv
// far-side model: one master and one slave on the shared two-wire bus
`timescale 1ns/1ps
module twb_far_end #(
    parameter [6:0] ADDR = 7'h5A
) (
    input  wire scl_i,
    input  wire sda_i,
    output reg  scl_pull_o,
    output reg  sda_pull_o
);
    reg [7:0] shift_reg;
    reg [7:0] rx_reg;
    reg [7:0] tx_reg;
    reg       act_reg;
    reg       sel_reg;
    reg       rd_reg;
    reg       adr_reg;
    integer   cnt;
    integer   stretch_ns;
    initial begin
        scl_pull_o = 1'b0;
        sda_pull_o = 1'b0;
        act_reg = 1'b0;
        stretch_ns = 0;
    end
    // start and stop seen with clock high
    always @(negedge sda_i) if (scl_i) begin
        act_reg = 1'b1;
        adr_reg = 1'b1;
        sel_reg = 1'b0;
        cnt = 0;
    end
    always @(posedge sda_i) if (scl_i) act_reg = 1'b0;
    // shift msb first, master nack ends a read
    always @(posedge scl_i) if (act_reg) begin
        shift_reg = {shift_reg[6:0], sda_i};
        cnt = cnt + 1;
        if (cnt == 8) rx_reg = shift_reg;
        if (cnt == 9 && rd_reg && sda_i) sel_reg = 1'b0;
    end
    // ack, read data and stretch at clock falls
    always @(negedge scl_i) if (act_reg) begin
        if (cnt == 8 && adr_reg) begin
            sel_reg = (shift_reg[7:1] == ADDR);
            rd_reg = shift_reg[0];
        end
        if (cnt == 8)
            sda_pull_o = sel_reg && !(rd_reg && !adr_reg);
        else
            sda_pull_o = sel_reg && rd_reg && !tx_reg[cnt == 9 ? 7 : 7 - cnt];
        if (cnt == 9) begin
            cnt = 0;
            adr_reg = 1'b0;
            if (sel_reg && stretch_ns > 0) begin
                scl_pull_o = 1'b1;
                #(stretch_ns) scl_pull_o = 1'b0;
            end
        end
    end
    // far master bit, waits for clock high
    task m_bit(input b, output s);
        integer w;
        begin
            sda_pull_o = !b;
            #40 scl_pull_o = 1'b0;
            // bounded wait for a stretching slave to let go
            for (w = 0; w < 500 && !scl_i; w = w + 1)
                #8;
            #80 s = sda_i;
            scl_pull_o = 1'b1;
            #40;
        end
    endtask
    // eight bits msb first then acknowledge
    task m_byte(input [7:0] b, input ack_low, output [7:0] got, output acked);
        integer i;
        reg     s;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                m_bit(b[i], s);
                got[i] = s;
            end
            m_bit(!ack_low, s);
            acked = !s;
        end
    endtask
    task m_start;
        begin
            sda_pull_o = 1'b0;
            #40 scl_pull_o = 1'b0;
            #80 sda_pull_o = 1'b1;
            #80 scl_pull_o = 1'b1;
            #40;
        end
    endtask
    task m_stop;
        begin
            sda_pull_o = 1'b1;
            #40 scl_pull_o = 1'b0;
            #80 sda_pull_o = 1'b0;
            #80;
        end
    endtask
endmodule

// ===== dv/two_wire_bus_protocol_test.sv
// self-checking bench for the two-wire bus protocol engine
`timescale 1ns/1ps
module two_wire_bus_protocol_test;
    localparam [6:0] FAR_ADDR = 7'h5A;
    logic       clk = 1'b0;
    logic       rst_n, gate, gcall_en, c_start, c_write, c_read, c_stop, c_ack, slv_ack, acked;
    logic [7:0] c_data, slv_tx, d, t, got;
    logic [6:0] own, a7;
    logic [7:0] exp_rx[$];
    wire        scl_oe, sda_oe, far_scl, far_sda, ready, done, nack, gc, rxv, busy;
    wire        srd, txq, rxn, sts, sps;
    integer     n_ss = 0, n_sp = 0, n_tq = 0, n_rn = 0;
    wire  [7:0] rx_data, rd_data;
    wire        scl_line, sda_line;
    integer     seed = 32'h6B03;
    integer     bad_count = 0;
    integer     n_checks = 0;
    int         k;
    always #4 clk = ~clk;
    assign scl_line = !(scl_oe | far_scl);
    assign sda_line = !(sda_oe | far_sda);
    twb_protocol #(.QTR_CYC(4)) twb_protocol_inst (
        .ref_clk_i(clk), .rst_n_i(rst_n), .bus_power_gate_bit_i(gate),
        .scl_i(scl_line), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe),
        .own_addr_i(own), .gcall_en_i(gcall_en), .cmd_start_i(c_start), .cmd_write_i(c_write),
        .cmd_read_i(c_read), .cmd_stop_i(c_stop), .cmd_data_i(c_data), .cmd_ack_i(c_ack),
        .cmd_ready_o(ready), .cmd_done_o(done), .cmd_nack_o(nack), .slv_tx_data_i(slv_tx),
        .slv_ack_i(slv_ack), .slv_addr_hit_o(), .slv_read_o(srd), .slv_gcall_o(gc), .slv_rx_valid_o(rxv),
        .slv_rx_data_o(rx_data), .slv_tx_req_o(txq), .slv_rx_nack_o(rxn), .bus_busy_o(busy),
        .rd_data_o(rd_data), .start_seen_o(sts), .stop_seen_o(sps)
    );
    twb_far_end #(.ADDR(FAR_ADDR)) twb_far_end_inst (
        .scl_i(scl_line), .sda_i(sda_line), .scl_pull_o(far_scl), .sda_pull_o(far_sda)
    );
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            n_checks++;
            if (seen !== exp) begin
                bad_count++;
                $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", n_checks, bad_count);
            if (bad_count == 0 && n_checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // master command: 0 start, 1 write, 2 read, 3 stop
    task cmd(input int kind, input [7:0] dat, input a);
        int i;
        begin
            for (i = 0; i < 9000 && ready !== 1'b1; i++)
                @(negedge clk);
            if (ready !== 1'b1) begin
                bad_count++;
                tally_and_finish;
            end
            {c_start, c_write, c_read, c_stop} = 4'h8 >> kind;
            c_data = dat;
            c_ack = a;
            @(negedge clk);
            {c_start, c_write, c_read, c_stop} = 4'h0;
            for (i = 0; i < 9000 && done !== 1'b1; i++)
                @(negedge clk);
            if (done !== 1'b1) begin
                bad_count++;
                tally_and_finish;
            end
        end
    endtask
    task fb(input [7:0] b, input a);
        twb_far_end_inst.m_byte(b, a, got, acked);
    endtask
    // bytes the design's slave side must deliver, in order
    always @(negedge clk) if (rxv === 1'b1) begin
        if (exp_rx.size() > 0)
            chk(rx_data, exp_rx.pop_front());
        else
            chk(rx_data, 32'hFFFF_FFFF);
    end
    // count condition and slave event pulses
    always @(negedge clk) begin
        n_ss += (sts === 1'b1);
        n_sp += (sps === 1'b1);
        n_tq += (txq === 1'b1);
        n_rn += (rxn === 1'b1);
    end
    initial begin
        #400000 bad_count++;
        tally_and_finish;
    end
    initial begin
        {rst_n, gate, gcall_en, c_start, c_write, c_read, c_stop, c_ack, slv_ack} = 9'h000;
        c_data = 8'h00;
        slv_tx = 8'h00;
        own = 7'h22;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        // design master writes to the far slave, then misses an address
        d = $random(seed);
        cmd(0, 8'h00, 1'b0);
        chk(busy, 1'b1);
        cmd(1, {FAR_ADDR, 1'b0}, 1'b0);
        chk(nack, 1'b0);
        cmd(1, d, 1'b0);
        chk(nack, 1'b0);
        chk(twb_far_end_inst.rx_reg, d);
        cmd(0, 8'h00, 1'b0);
        cmd(1, {FAR_ADDR ^ 7'h01, 1'b0}, 1'b0);
        chk(nack, 1'b1);
        // repeated start into a stretched read
        t = $random(seed);
        twb_far_end_inst.tx_reg = t;
        twb_far_end_inst.stretch_ns = 400;
        cmd(0, 8'h00, 1'b0);
        chk(busy, 1'b1);
        cmd(1, {FAR_ADDR, 1'b1}, 1'b0);
        chk(nack, 1'b0);
        cmd(2, 8'h00, 1'b1);
        chk(rd_data, t);
        cmd(2, 8'h00, 1'b0);
        chk(rd_data, t);
        cmd(3, 8'h00, 1'b0);
        for (k = 0; k < 50 && busy !== 1'b0; k++)
            @(negedge clk);
        chk(busy, 1'b0);
        // far master writes to and reads from the design's slave
        d = $random(seed);
        own = {3'b001, d[3:0]};
        t = $random(seed);
        slv_tx = t;
        twb_far_end_inst.m_start;
        fb({own, 1'b0}, 1'b0);
        chk(acked, 1'b1);
        for (k = 0; k < 2; k++) begin
            d = $random(seed);
            exp_rx.push_back(d);
            @(negedge clk) slv_ack = (k == 0);
            fb(d, 1'b0);
            chk(acked, k == 0);
        end
        twb_far_end_inst.m_start;
        fb({own, 1'b1}, 1'b0);
        chk(acked, 1'b1);
        chk(srd, 1'b1);
        fb(8'hFF, 1'b0);
        chk(got, t);
        twb_far_end_inst.m_stop;
        // general call on and off, reserved address, gated block
        for (k = 0; k < 4; k++) begin
            @(negedge clk);
            a7 = (k < 2) ? 7'h00 : ((k == 2) ? 7'h7B : 7'h22);
            own = (k == 2) ? 7'h7B : 7'h22;
            {gcall_en, gate, slv_ack} = {k == 0, k == 3, 1'b1};
            twb_far_end_inst.m_start;
            fb({a7, 1'b0}, 1'b0);
            chk(acked, k == 0);
            if (k == 0) begin
                chk(gc, 1'b1);
                exp_rx.push_back(8'h3C);
                fb(8'h3C, 1'b0);
            end
            twb_far_end_inst.m_stop;
        end
        @(negedge clk) gate = 1'b0;
        repeat (4) @(negedge clk);
        chk(exp_rx.size(), 0);
        chk(n_ss, 8);
        chk(n_sp, 5);
        chk(n_tq, 1);
        chk(n_rn, 1);
        tally_and_finish;
    end
endmodule
